// *** design/iwu_defs.svh ***
// constants for the interrupt and watchdog unit
`ifndef IWU_DEFS_SVH
`define IWU_DEFS_SVH
`define IWU_BIT_T0       0
`define IWU_BIT_PB       1
`define IWU_BIT_EXT      2
`define IWU_BIT_T1       3
`define IWU_BIT_WDT      6
`define IWU_VEC_SW       11'h001
`define IWU_VEC_HW       11'h008
`define IWU_FLAGS_RST    8'h00
`define IWU_OSC_HZ       32768
`define IWU_US_PER_S     1000000
`define IWU_T_3P5_US     3500
`define IWU_T_15_US      15000
`define IWU_T_60_US      60000
`define IWU_T_250_US     250000
`define IWU_PIN_MASK     6'h3F
`endif

// *** design/iwu_pkg.sv ***
// types of the interrupt and watchdog unit
package iwu_pkg;
    typedef enum logic [1:0] {IWU_TO_3P5, IWU_TO_15, IWU_TO_60, IWU_TO_250} iwu_period_t;
    typedef enum logic {IWU_MODE_RESET, IWU_MODE_IRQ} iwu_wdt_mode_t;
endpackage

// *** design/iwu_watchdog.sv ***
// watchdog counter with optional prescaler
`timescale 1ns/10ps
`include "iwu_defs.svh"
module iwu_watchdog
    import iwu_pkg::*;
#(
    parameter int OSC_DIV = 6104
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          ce,
    input  wire logic          run,
    input  wire logic          clear,
    input  wire logic          pre_on,
    input  wire logic [2:0]    rate,
    input  wire iwu_wdt_mode_t mode,
    input  wire iwu_period_t   period,
    output logic               expire
);
    initial begin
        if (OSC_DIV < 1 || OSC_DIV > 65536) $error("OSC_DIV out of range");
    end

    // oscillator ticks per base period
    function automatic logic [13:0] ticks(input iwu_period_t p);
        case (p)
            IWU_TO_3P5: ticks = 14'(longint'(`IWU_OSC_HZ) * `IWU_T_3P5_US / `IWU_US_PER_S);
            IWU_TO_15:  ticks = 14'(longint'(`IWU_OSC_HZ) * `IWU_T_15_US / `IWU_US_PER_S);
            IWU_TO_60:  ticks = 14'(longint'(`IWU_OSC_HZ) * `IWU_T_60_US / `IWU_US_PER_S);
            default:    ticks = 14'(longint'(`IWU_OSC_HZ) * `IWU_T_250_US / `IWU_US_PER_S);
        endcase
    endfunction

    logic [15:0] osc_cnt, next_osc_cnt;
    logic [13:0] wdt_cnt, next_wdt_cnt;
    logic [7:0]  pre_cnt, next_pre_cnt;
    logic        next_expire;
    logic [7:0]  pre_lim;
    logic        osc_tick;

    always_comb begin
        if (mode == IWU_MODE_IRQ)
            pre_lim = 8'((9'h001 << ({1'b0, rate} + 4'h1)) - 9'h001);
        else
            pre_lim = 8'((9'h001 << rate) - 9'h001);
        osc_tick     = (osc_cnt == 16'(OSC_DIV - 1));
        next_osc_cnt = osc_tick ? 16'h0000 : osc_cnt + 16'h0001;
        next_pre_cnt = pre_cnt;
        next_wdt_cnt = wdt_cnt;
        next_expire  = 1'b0;
        if (clear) begin
            next_wdt_cnt = 14'h0000;
            next_pre_cnt = 8'h00;
        end else if (run && osc_tick) begin
            if (pre_on && pre_cnt != pre_lim) begin
                next_pre_cnt = pre_cnt + 8'h01;
            end else begin
                next_pre_cnt = 8'h00;
                if (wdt_cnt >= ticks(period) - 14'h0001) begin
                    next_wdt_cnt = 14'h0000;
                    next_expire  = 1'b1;
                end else begin
                    next_wdt_cnt = wdt_cnt + 14'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_cnt <= 16'h0000;
            wdt_cnt <= 14'h0000;
            pre_cnt <= 8'h00;
            expire  <= 1'b0;
        end else if (ce) begin
            osc_cnt <= next_osc_cnt;
            wdt_cnt <= next_wdt_cnt;
            pre_cnt <= next_pre_cnt;
            expire  <= next_expire;
        end
    end

    a_clear_counts: assert property (@(posedge clk) disable iff (rst)
        ce && clear |=> wdt_cnt == 14'h0000 && pre_cnt == 8'h00 && !expire)
        else $error("watchdog clear did not zero the counters");
    a_run_gate: assert property (@(posedge clk) disable iff (rst)
        ce && !run && !clear |=> wdt_cnt == $past(wdt_cnt) && !expire)
        else $error("watchdog counted while stopped");
endmodule

// *** design/iwu_top.sv ***
// interrupt controller with watchdog, top level
`timescale 1ns/10ps
`include "iwu_defs.svh"
module iwu_top
    import iwu_pkg::*;
#(
    parameter int OSC_DIV = 6104
) (
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    input  wire logic                 CE,
    input  wire logic                 WDT_CFG_ENABLE,
    input  wire iwu_pkg::iwu_wdt_mode_t WDT_CFG_MODE,
    input  wire iwu_pkg::iwu_period_t WDT_CFG_PERIOD,
    input  wire logic                 WATCHDOG_RUN_BIT,
    input  wire logic                 PRESCALER_ASSIGN_BIT,
    input  wire logic [2:0]           PRESCALER_RATE_FIELD,
    input  wire logic                 WATCHDOG_CLEAR_INSTRUCTION,
    input  wire logic                 ENABLE_IRQ_INSTRUCTION,
    input  wire logic                 DISABLE_IRQ_INSTRUCTION,
    input  wire logic                 RETURN_FROM_IRQ_INSTRUCTION,
    input  wire logic                 SOFT_IRQ_INSTRUCTION,
    input  wire logic                 INSN_BOUNDARY,
    input  wire logic                 TIMER0_WRAP,
    input  wire logic                 TIMER1_WRAP,
    input  wire logic [5:0]           PORT_B_PINS,
    input  wire logic [5:0]           PORT_B_IS_INPUT,
    input  wire logic [5:0]           PORT_B_WAKE_ENABLE,
    input  wire logic                 EXTERNAL_IRQ_SELECT,
    input  wire logic                 EXTERNAL_EDGE_SELECT,
    input  wire logic [7:0]           IRQ_ENABLE_REGISTER,
    input  wire logic                 FLAG_WRITE,
    input  wire logic [7:0]           FLAG_WRITE_DATA,
    output logic [7:0]                IRQ_FLAG_REGISTER,
    output logic                      GLOBAL_IRQ_ENABLE,
    output logic                      TIMEOUT_STATUS_FLAG,
    output logic                      WDT_CHIP_RESET,
    output logic                      VECTOR_TAKE,
    output logic [10:0]               VECTOR_ADDR
);
    import iwu_pkg::*;

    // pin synchronisers
    logic [5:0] pb_s1, pb_s2, pb_old;
    logic [2:0] pb_arm;
    logic       pb_primed;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pb_s1     <= 6'h00;
            pb_s2     <= 6'h00;
            pb_old    <= 6'h00;
            pb_arm    <= 3'h0;
        end else if (CE) begin
            pb_s1     <= PORT_B_PINS;
            pb_s2     <= pb_s1;
            pb_old    <= pb_s2;
            pb_arm    <= {pb_arm[1:0], 1'b1};
        end
    end
    // compare only once pb_s2 and pb_old both hold sampled pins
    assign pb_primed = pb_arm[2];

    logic wdt_expire;
    logic wdt_clear;
    assign wdt_clear = WATCHDOG_CLEAR_INSTRUCTION && PRESCALER_ASSIGN_BIT;

    iwu_watchdog #(.OSC_DIV(OSC_DIV)) u_wdt (
        .clk    (CLK),
        .rst    (SYS_RST),
        .ce     (CE),
        .run    (WDT_CFG_ENABLE && WATCHDOG_RUN_BIT),
        .clear  (wdt_clear),
        .pre_on (PRESCALER_ASSIGN_BIT),
        .rate   (PRESCALER_RATE_FIELD),
        .mode   (WDT_CFG_MODE),
        .period (WDT_CFG_PERIOD),
        .expire (wdt_expire)
    );

    // event detection
    logic [5:0] pb_mask, pb_change;
    logic       ext_rise, ext_fall, ext_event;
    logic [7:0] events;
    always_comb begin
        pb_mask = PORT_B_IS_INPUT & PORT_B_WAKE_ENABLE & `IWU_PIN_MASK;
        if (EXTERNAL_IRQ_SELECT)
            pb_mask[0] = 1'b0;
        pb_change = pb_primed ? ((pb_s2 ^ pb_old) & pb_mask) : 6'h00;
        ext_rise  = pb_primed && pb_s2[0] && !pb_old[0];
        ext_fall  = pb_primed && !pb_s2[0] && pb_old[0];
        ext_event = EXTERNAL_IRQ_SELECT && (EXTERNAL_EDGE_SELECT ? ext_rise : ext_fall);
        events = 8'h00;
        events[`IWU_BIT_T0]  = TIMER0_WRAP;
        events[`IWU_BIT_T1]  = TIMER1_WRAP;
        events[`IWU_BIT_PB]  = |pb_change;
        events[`IWU_BIT_EXT] = ext_event;
        events[`IWU_BIT_WDT] = wdt_expire && (WDT_CFG_MODE == IWU_MODE_IRQ);
    end

    // flags, global enable, vectoring
    logic [7:0]  flags, next_flags;
    logic        global_irq_enable, next_gie;
    logic        tsf, next_tsf;
    logic        next_chip_rst;
    logic        next_vtake;
    logic [10:0] vaddr, next_vaddr;
    logic        hw_pending;

    always_comb begin
        next_flags = flags;
        if (FLAG_WRITE)
            next_flags = flags & FLAG_WRITE_DATA;
        next_flags = next_flags | events;
        hw_pending = |(flags & IRQ_ENABLE_REGISTER);
        next_gie   = global_irq_enable;
        if (ENABLE_IRQ_INSTRUCTION || RETURN_FROM_IRQ_INSTRUCTION)
            next_gie = 1'b1;
        if (DISABLE_IRQ_INSTRUCTION)
            next_gie = 1'b0;
        next_vtake = 1'b0;
        next_vaddr = vaddr;
        if (INSN_BOUNDARY && SOFT_IRQ_INSTRUCTION) begin
            next_vtake = 1'b1;
            next_vaddr = `IWU_VEC_SW;
            next_gie   = 1'b0;
        end else if (INSN_BOUNDARY && global_irq_enable && hw_pending) begin
            next_vtake = 1'b1;
            next_vaddr = `IWU_VEC_HW;
            next_gie   = 1'b0;
        end
        next_tsf = tsf;
        if (wdt_clear)
            next_tsf = 1'b1;
        if (wdt_expire)
            next_tsf = 1'b0;
        next_chip_rst = wdt_expire && (WDT_CFG_MODE == IWU_MODE_RESET);
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            flags    <= `IWU_FLAGS_RST;
            global_irq_enable      <= 1'b0;
            tsf      <= 1'b1;
            vaddr    <= `IWU_VEC_HW;
            IRQ_FLAG_REGISTER   <= `IWU_FLAGS_RST;
            GLOBAL_IRQ_ENABLE   <= 1'b0;
            TIMEOUT_STATUS_FLAG <= 1'b1;
            WDT_CHIP_RESET      <= 1'b0;
            VECTOR_TAKE         <= 1'b0;
            VECTOR_ADDR         <= `IWU_VEC_HW;
        end else if (CE) begin
            flags    <= next_flags;
            global_irq_enable      <= next_gie;
            tsf      <= next_tsf;
            vaddr    <= next_vaddr;
            IRQ_FLAG_REGISTER   <= next_flags & IRQ_ENABLE_REGISTER;
            GLOBAL_IRQ_ENABLE   <= next_gie;
            TIMEOUT_STATUS_FLAG <= next_tsf;
            WDT_CHIP_RESET      <= next_chip_rst;
            VECTOR_TAKE         <= next_vtake;
            VECTOR_ADDR         <= next_vaddr;
        end
    end

    // checks
    a_sw_vector: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && INSN_BOUNDARY && SOFT_IRQ_INSTRUCTION |=> VECTOR_TAKE && VECTOR_ADDR == `IWU_VEC_SW
            && !GLOBAL_IRQ_ENABLE)
        else $error("software vector not taken");
    a_hw_vector: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && INSN_BOUNDARY && !SOFT_IRQ_INSTRUCTION && global_irq_enable && hw_pending
            |=> VECTOR_TAKE && VECTOR_ADDR == `IWU_VEC_HW && !GLOBAL_IRQ_ENABLE)
        else $error("hardware vector not taken");
    a_hw_blocked: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && !global_irq_enable && !SOFT_IRQ_INSTRUCTION |=> !VECTOR_TAKE)
        else $error("vector taken with global enable low");
    a_flag_sticky: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && flags[`IWU_BIT_T0] && !(FLAG_WRITE && !FLAG_WRITE_DATA[`IWU_BIT_T0])
            |=> flags[`IWU_BIT_T0])
        else $error("timer0 flag lost");
    a_t1_set: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && TIMER1_WRAP |=> flags[`IWU_BIT_T1])
        else $error("timer1 flag not set");
    a_t0_set: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && TIMER0_WRAP |=> flags[`IWU_BIT_T0])
        else $error("timer0 flag not set");
    a_flag_view: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE |=> (IRQ_FLAG_REGISTER & ~$past(IRQ_ENABLE_REGISTER)) == 8'h00)
        else $error("masked flag visible");
    a_wdt_irq: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && wdt_expire && WDT_CFG_MODE == IWU_MODE_IRQ |=> flags[`IWU_BIT_WDT] && !tsf)
        else $error("watchdog flag not set");
    a_wdt_reset: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && wdt_expire && WDT_CFG_MODE == IWU_MODE_RESET |=> WDT_CHIP_RESET ##1 !WDT_CHIP_RESET
            || !CE)
        else $error("watchdog reset pulse wrong");
    a_wdt_clear: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && wdt_clear && !wdt_expire |=> tsf)
        else $error("timeout status not set by clear");
    a_reti_gie: assert property (@(posedge CLK) disable iff (SYS_RST)
        CE && RETURN_FROM_IRQ_INSTRUCTION && !DISABLE_IRQ_INSTRUCTION
            && !(INSN_BOUNDARY && (SOFT_IRQ_INSTRUCTION || (global_irq_enable && hw_pending)))
            |=> GLOBAL_IRQ_ENABLE)
        else $error("return did not set global enable");
endmodule

// *** tb/iwu_core_model.sv ***
// processor core model issuing instructions at boundaries
`timescale 1ns/10ps
module iwu_core_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       op_vld,
    input  wire logic [2:0] op,
    output logic            en_irq,
    output logic            dis_irq,
    output logic            ret_irq,
    output logic            soft_irq,
    output logic            wdt_clr,
    output logic            bnd
);
    logic last_en;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_irq   <= 1'b0;
            dis_irq  <= 1'b0;
            ret_irq  <= 1'b0;
            soft_irq <= 1'b0;
            wdt_clr  <= 1'b0;
            bnd      <= 1'b0;
            last_en  <= 1'b0;
        end else begin
            en_irq   <= op_vld && op == 3'h1;
            dis_irq  <= op_vld && op == 3'h2;
            ret_irq  <= op_vld && op == 3'h3 && !last_en;
            soft_irq <= op_vld && op == 3'h4;
            wdt_clr  <= op_vld && op == 3'h5;
            bnd      <= op_vld;
            if (op_vld) begin
                last_en <= op == 3'h1;
            end
        end
    end
endmodule

// *** tb/interrupt_and_watchdog_unit_tb.sv ***
// self-checking bench for the interrupt and watchdog unit
`timescale 1ns/10ps
module interrupt_and_watchdog_unit_tb;
    import iwu_pkg::*;
    localparam int DIV = 2;
    int            tk[4] = '{114, 491, 1966, 8192};
    logic          clk = 1'b0;
    logic          rst = 1'b1;
    iwu_wdt_mode_t mode = IWU_MODE_IRQ;
    iwu_period_t   per = IWU_TO_3P5;
    logic          run = 1'b0;
    logic          wen = 1'b1;
    logic [5:0]    pin_in = 6'h3F;
    logic [5:0]    wake = 6'h3F;
    logic          pre = 1'b0;
    logic [2:0]    rate = 3'h0;
    logic          op_vld = 1'b0;
    logic [2:0]    op = 3'h0;
    logic          t0 = 1'b0;
    logic          t1 = 1'b0;
    logic [5:0]    pins = 6'h00;
    logic          external_irq_select = 1'b0;
    logic          esel = 1'b0;
    logic [7:0]    ien = 8'h00;
    logic          fw = 1'b0;
    logic [7:0]    fwd = 8'hFF;
    logic [7:0]    flags;
    logic [10:0]   vaddr;
    logic          gen, tos, crst, take, en_i, dis_i, ret_i, soft_i, clr_i, bnd;
    int            error_cnt = 0;
    int            num_checks = 0;
    int            n;
    iwu_core_model u_core (.clk(clk), .rst(rst), .op_vld(op_vld), .op(op), .en_irq(en_i),
        .dis_irq(dis_i), .ret_irq(ret_i), .soft_irq(soft_i), .wdt_clr(clr_i), .bnd(bnd));
    iwu_top #(.OSC_DIV(DIV)) u_dut (.CLK(clk), .SYS_RST(rst), .CE(1'b1),
        .WDT_CFG_ENABLE(wen), .WDT_CFG_MODE(mode), .WDT_CFG_PERIOD(per),
        .WATCHDOG_RUN_BIT(run), .PRESCALER_ASSIGN_BIT(pre), .PRESCALER_RATE_FIELD(rate),
        .WATCHDOG_CLEAR_INSTRUCTION(clr_i), .ENABLE_IRQ_INSTRUCTION(en_i),
        .DISABLE_IRQ_INSTRUCTION(dis_i), .RETURN_FROM_IRQ_INSTRUCTION(ret_i),
        .SOFT_IRQ_INSTRUCTION(soft_i), .INSN_BOUNDARY(bnd), .TIMER0_WRAP(t0),
        .TIMER1_WRAP(t1), .PORT_B_PINS(pins), .PORT_B_IS_INPUT(pin_in),
        .PORT_B_WAKE_ENABLE(wake), .EXTERNAL_IRQ_SELECT(external_irq_select), .EXTERNAL_EDGE_SELECT(esel),
        .IRQ_ENABLE_REGISTER(ien), .FLAG_WRITE(fw), .FLAG_WRITE_DATA(fwd),
        .IRQ_FLAG_REGISTER(flags), .GLOBAL_IRQ_ENABLE(gen), .TIMEOUT_STATUS_FLAG(tos),
        .WDT_CHIP_RESET(crst), .VECTOR_TAKE(take), .VECTOR_ADDR(vaddr));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (exp !== got) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic run_op(input logic [2:0] o);
        @(posedge clk);
        op <= o;
        op_vld <= 1'b1;
        @(posedge clk);
        op_vld <= 1'b0;
        tick(1);
    endtask
    task automatic pulse(input logic which);
        @(posedge clk);
        if (which) t1 <= 1'b1;
        else t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
        t1 <= 1'b0;
        tick(1);
    endtask
    task automatic fwrite(input logic [7:0] d);
        @(posedge clk);
        fw <= 1'b1;
        fwd <= d;
        @(posedge clk);
        fw <= 1'b0;
        tick(1);
    endtask
    task automatic set_ien(input logic [7:0] v);
        @(posedge clk);
        ien <= v;
        tick(1);
    endtask
    task automatic setp(input logic [5:0] v);
        @(posedge clk);
        pins <= v;
        tick(6);
    endtask
    task automatic wdt_run(input int p, input iwu_wdt_mode_t m, input logic ps,
                           input logic [2:0] r, input int exp);
        @(posedge clk);
        per <= iwu_period_t'(p[1:0]);
        mode <= m;
        pre <= ps;
        rate <= r;
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        n = 0;
        tick(1);
        while (n < 70000 && !(m == IWU_MODE_IRQ ? flags[6] === 1'b1 : crst === 1'b1)) begin
            tick(1);
            n++;
        end
        chk("wdt_period", exp, n);
        chk("timeout_flag", 11'h000, 11'(tos));
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 clk = ~clk;
    end
    initial begin
        repeat (95000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk("flag_reg", 11'h000, 11'(flags));
        chk("global_en", 11'h000, 11'(gen));
        chk("timeout_flag", 11'h001, 11'(tos));
        pulse(1'b0);
        chk("flag_reg", 11'h000, 11'(flags));
        set_ien(8'h01);
        chk("flag_reg", 11'h001, 11'(flags));
        run_op(3'h0);
        chk("vec_take", 11'h000, 11'(take));
        run_op(3'h4);
        chk("vec_take", 11'h001, 11'(take));
        chk("vec_addr", 11'h001, vaddr);
        run_op(3'h3);
        chk("global_en", 11'h001, 11'(gen));
        run_op(3'h0);
        chk("vec_take", 11'h001, 11'(take));
        chk("vec_addr", 11'h008, vaddr);
        chk("global_en", 11'h000, 11'(gen));
        run_op(3'h1);
        chk("global_en", 11'h001, 11'(gen));
        run_op(3'h0);
        chk("vec_take", 11'h001, 11'(take));
        fwrite(8'hFF);
        chk("flag_reg", 11'h001, 11'(flags));
        fwrite(8'hFE);
        chk("flag_reg", 11'h000, 11'(flags));
        run_op(3'h1);
        run_op(3'h2);
        chk("global_en", 11'h000, 11'(gen));
        set_ien(8'h08);
        pulse(1'b1);
        chk("flag_reg", 11'h008, 11'(flags));
        fwrite(8'hF7);
        set_ien(8'h02);
        setp(6'h20);
        chk("flag_reg", 11'h002, 11'(flags));
        fwrite(8'hFD);
        @(posedge clk);
        wake <= 6'h1F;
        setp(6'h00);
        chk("flag_reg", 11'h000, 11'(flags));
        @(posedge clk);
        wake <= 6'h3F;
        pin_in <= 6'h1F;
        setp(6'h20);
        chk("flag_reg", 11'h000, 11'(flags));
        @(posedge clk);
        pin_in <= 6'h3F;
        external_irq_select <= 1'b1;
        setp(6'h21);
        chk("flag_reg", 11'h000, 11'(flags));
        set_ien(8'h04);
        @(posedge clk);
        esel <= 1'b1;
        setp(6'h20);
        chk("flag_reg", 11'h000, 11'(flags));
        setp(6'h21);
        chk("flag_reg", 11'h004, 11'(flags));
        fwrite(8'hFB);
        @(posedge clk);
        esel <= 1'b0;
        setp(6'h20);
        chk("flag_reg", 11'h004, 11'(flags));
        set_ien(8'h40);
        tick(600);
        chk("flag_reg", 11'h000, 11'(flags));
        @(posedge clk);
        wen <= 1'b0;
        run <= 1'b1;
        tick(600);
        chk("flag_reg", 11'h000, 11'(flags));
        @(posedge clk);
        wen <= 1'b1;
        for (int p = 0; p < 4; p++) begin
            wdt_run(p, IWU_MODE_IRQ, 1'b0, 3'h0, tk[p] * DIV);
        end
        wdt_run(0, IWU_MODE_RESET, 1'b1, 3'h0, tk[0] * DIV);
        wdt_run(0, IWU_MODE_IRQ, 1'b1, 3'h0, tk[0] * 2 * DIV);
        wdt_run(0, IWU_MODE_IRQ, 1'b1, 3'h2, tk[0] * 8 * DIV);
        wdt_run(0, IWU_MODE_IRQ, 1'b1, 3'h7, tk[0] * 256 * DIV);
        run_op(3'h1);
        run_op(3'h0);
        chk("vec_take", 11'h001, 11'(take));
        run_op(3'h5);
        chk("timeout_flag", 11'h001, 11'(tos));
        finish_test();
    end
endmodule
